// *** inc/srap_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the serial register access port
package srap_pkg;

    // Address byte layout
    localparam int unsigned SRAP_ADDR_BITS  = 8;           // Bits in the address byte
    localparam int unsigned SRAP_DIR_POS    = 7;           // Direction select position
    localparam int unsigned SRAP_IDX_W      = 7;           // Register index width
    localparam int unsigned SRAP_DATA_W     = 24;          // Widest data word

    // Direction select encoding
    typedef enum logic {
        SRAP_DIR_WRITE = 1'h0,                             // Write the addressed register
        SRAP_DIR_READ  = 1'h1                              // Read the addressed register
    } srap_dir_t;

    // Register map boundaries, index of the first register of the 24-bit and 16-bit maps
    localparam logic [6:0] SRAP_FIRST_WORD_IDX = 7'h20;    // First 24-bit register
    localparam logic [6:0] SRAP_FIRST_SEQ_IDX  = 7'h3A;    // First 16-bit register

    // Data bytes per map
    localparam logic [1:0] SRAP_BYTES_CTRL = 2'h1;         // 8-bit control map
    localparam logic [1:0] SRAP_BYTES_SEQ  = 2'h2;         // 16-bit sequencer map
    localparam logic [1:0] SRAP_BYTES_WORD = 2'h3;         // 24-bit data map

    // Serial clock edge counts within a frame
    localparam logic [5:0] SRAP_ADDR_LAST_RISE = 6'h07;    // Count before the 8th rising edge
    localparam logic [5:0] SRAP_DOUT_FALL      = 6'h09;    // Rises seen at the 9th falling edge
    localparam logic [5:0] SRAP_CNT_MAX        = 6'h3F;    // Edge counter saturation

    // Values after reset
    localparam logic SRAP_PIN_IDLE = 1'h1;                 // Shared pin level while idle
    localparam logic SRAP_SYNC_CS  = 1'h1;                 // Chip select synchroniser reset

endpackage : srap_pkg

// *** hw/srap_port.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module srap_port
    import srap_pkg::*;
#(
    parameter logic [6:0] FirstWordIdx = SRAP_FIRST_WORD_IDX,  // First 24-bit index
    parameter logic [6:0] FirstSeqIdx  = SRAP_FIRST_SEQ_IDX    // First 16-bit index
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        chipSelectN,
    input  wire logic        serialIn,
    output logic             sharedOutIrqPin,
    output logic             sharedOutIrqPinOe,
    // Core status
    input  wire logic        wakeDone,
    input  wire logic        opBusy,
    input  wire logic        interruptN,
    // Core register access
    input  wire logic [23:0] regRdData,
    output logic             regRdStb,
    output logic             regWrStb,
    output logic [6:0]       regIdx,
    output logic [23:0]      regWrData,
    output logic             opAbort
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Maps must appear in ascending order of index
    if (FirstWordIdx > FirstSeqIdx) begin : g_badMap
        $error("srap_port: 24-bit map must start below the 16-bit map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Number of data bytes behind a register index
    function automatic logic [1:0] wordBytes(input logic [6:0] idx);
        logic [1:0] nb;
        nb = SRAP_BYTES_SEQ;
        if (idx < FirstWordIdx) begin
            nb = SRAP_BYTES_CTRL;
        end else if (idx < FirstSeqIdx) begin
            nb = SRAP_BYTES_WORD;
        end
        return nb;
    endfunction : wordBytes

    // Count of rising edges seen just before the commit edge
    function automatic logic [5:0] commitCount(input logic [1:0] nb);
        logic [5:0] edges;
        edges = {1'h0, nb, 3'h0} + 6'h07;
        return edges;
    endfunction : commitCount

    // Left-justify a word so that its MSB leaves first
    function automatic logic [23:0] leftJustify(input logic [23:0] w, input logic [1:0] nb);
        logic [23:0] r;
        r = w;
        if (nb == SRAP_BYTES_CTRL) begin
            r = {w[7:0], 16'h0000};
        end else if (nb == SRAP_BYTES_SEQ) begin
            r = {w[15:0], 8'h00};
        end
        return r;
    endfunction : leftJustify

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    // Link side, cleared at every frame start
    logic        frameRstN;                 // Low while idle or in reset
    logic [5:0]  bitCnt_q;                  // Rising edges seen in this frame
    logic [23:0] inShift_q;                 // Received bits, newest in bit 0
    srap_dir_t   dir_q;                     // Direction of this frame
    logic [1:0]  nBytes_q;                  // Data bytes of this frame
    logic        addrDone_q;                // Address byte complete
    logic        dataPhase_q;               // Pin now carries read data
    logic [23:0] outShift_q;                // Read data still to send
    logic        doutBit_q;                 // Read data bit on the pin
    // Link side, kept across frames
    logic [6:0]  xferIdx_q;                 // Index of the last address byte
    logic [23:0] wrData_q;                  // Last committed write word
    logic        wrTgl_q;                   // Toggles per committed write
    logic        rdTgl_q;                   // Toggles per read request
    // Received word including the bit on the pin now
    logic [23:0] inWord;
    logic [6:0]  inIdx;
    logic        commitEdge;

    // System side
    logic [2:0]  wrSync_q;                  // Write toggle synchroniser
    logic [2:0]  rdSync_q;                  // Read toggle synchroniser
    logic [1:0]  csSync_q;                  // Chip select synchroniser
    logic        wrEvent;                   // One cycle per committed write
    logic        rdEvent;                   // One cycle per read request
    logic        rdPend_q;                  // Read word capture cycle
    logic [23:0] rdWord_q;                  // Word waiting for the link
    logic        irqShow_q;                 // Interrupt level for the pin
    logic        pinOe_q;                   // Pin driven while selected
    logic        regRdStb_q;
    logic        regWrStb_q;
    logic [6:0]  regIdx_q;
    logic [23:0] regWrData_q;
    logic        opAbort_q;

    ////////////////////////////////////////////////////////////////////////////
    // Link side receive, clocked on rising serial clock edges

    // Frame reset: idle chip select clears the frame logic
    // restart on select
    assign frameRstN = rstn & ~chipSelectN;

    assign inWord = {inShift_q[22:0], serialIn};
    assign inIdx  = inWord[6:0];

    assign commitEdge = addrDone_q && (dir_q == SRAP_DIR_WRITE)
                        && (bitCnt_q == commitCount(nBytes_q));

    // Edge counter, saturating so long frames stay harmless
    // frame bounded by select
    always_ff @(posedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            bitCnt_q <= 6'h00;
        end else if (bitCnt_q != SRAP_CNT_MAX) begin
            bitCnt_q <= bitCnt_q + 6'h01;
        end
    end

    // Input shift register
    // sample on rise
    always_ff @(posedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            inShift_q <= 24'h000000;
        end else begin
            inShift_q <= inWord;
        end
    end

    // Address byte decode on the 8th rising edge
    // address byte first
    always_ff @(posedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            dir_q      <= SRAP_DIR_WRITE;
            nBytes_q   <= SRAP_BYTES_CTRL;
            addrDone_q <= 1'h0;
        end else if (!addrDone_q && bitCnt_q == SRAP_ADDR_LAST_RISE) begin
            dir_q      <= srap_dir_t'(inWord[SRAP_DIR_POS]);
            nBytes_q   <= wordBytes(inIdx);
            addrDone_q <= 1'h1;
        end
    end

    // Index and toggles survive the end of the frame for the crossing
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            xferIdx_q <= 7'h00;
            rdTgl_q   <= 1'h0;
        end else if (!addrDone_q && bitCnt_q == SRAP_ADDR_LAST_RISE) begin
            xferIdx_q <= inIdx;
            // Ask the system side for the word as soon as the index is known
            if (inWord[SRAP_DIR_POS] == SRAP_DIR_READ) begin
                rdTgl_q <= ~rdTgl_q;
            end
        end
    end

    // Write word commit; a frame that ends early never reaches this edge
    // abort by early rise
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            wrData_q <= 24'h000000;
            wrTgl_q  <= 1'h0;
        end else if (frameRstN && commitEdge) begin
            // Clear bytes beyond the word, the address byte among them
            wrData_q <= inWord & {{8{nBytes_q == SRAP_BYTES_WORD}},
                                  {8{nBytes_q != SRAP_BYTES_CTRL}}, 8'hFF};
            wrTgl_q  <= ~wrTgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side transmit, clocked on falling serial clock edges

    // Read data takes over the pin at the 9th falling edge
    // change on fall
    always_ff @(negedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            dataPhase_q <= 1'h0;
            outShift_q  <= 24'h000000;
            doutBit_q   <= SRAP_PIN_IDLE;
        end else if (!dataPhase_q) begin
            if (dir_q == SRAP_DIR_READ && bitCnt_q == SRAP_DOUT_FALL) begin
                dataPhase_q <= 1'h1;
                // Word has stood still since the host paused the clock
                {doutBit_q, outShift_q} <= {leftJustify(rdWord_q, nBytes_q), 1'h0};
            end
        end else begin
            doutBit_q  <= outShift_q[23];
            outShift_q <= {outShift_q[22:0], 1'h0};
        end
    end

    // Pin selects interrupt level or read data
    // interrupt while selected
    assign sharedOutIrqPin   = dataPhase_q ? doutBit_q : irqShow_q;
    assign sharedOutIrqPinOe = pinOe_q;

    ////////////////////////////////////////////////////////////////////////////
    // System side crossings

    // Toggle synchronisers, third stage only feeds the edge detect
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrSync_q <= 3'h0;
            rdSync_q <= 3'h0;
        end else begin
            wrSync_q <= {wrSync_q[1:0], wrTgl_q};
            rdSync_q <= {rdSync_q[1:0], rdTgl_q};
        end
    end

    assign wrEvent = wrSync_q[2] ^ wrSync_q[1];
    assign rdEvent = rdSync_q[2] ^ rdSync_q[1];

    // Chip select level synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csSync_q <= {SRAP_SYNC_CS, SRAP_SYNC_CS};
        end else begin
            csSync_q <= {csSync_q[0], chipSelectN};
        end
    end

    // Interrupt level and drive enable for the shared pin
    // show interrupt level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqShow_q <= SRAP_PIN_IDLE;
            pinOe_q   <= 1'h0;
        end else begin
            irqShow_q <= csSync_q[1] ? SRAP_PIN_IDLE : interruptN;
            pinOe_q   <= ~csSync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System side register access

    // Strobes to the core, dropped while the device is still waking
    // ignore before wakeup
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdStb_q <= 1'h0;
            regWrStb_q <= 1'h0;
            rdPend_q   <= 1'h0;
        end else begin
            regRdStb_q <= rdEvent & wakeDone;
            regWrStb_q <= wrEvent & wakeDone;
            rdPend_q   <= rdEvent;
        end
    end

    // Index and write word, held stable until the next access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regIdx_q    <= 7'h00;
            regWrData_q <= 24'h000000;
        end else if (wrEvent || rdEvent) begin
            regIdx_q <= xferIdx_q;
            if (wrEvent) begin
                regWrData_q <= wrData_q;
            end
        end
    end

    // Any accepted write stops a running calibration or conversion
    // write aborts operation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opAbort_q <= 1'h0;
        end else begin
            opAbort_q <= wrEvent & wakeDone & opBusy;
        end
    end

    // Capture the core's answer; zeros while still waking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdWord_q <= 24'h000000;
        end else if (rdPend_q) begin
            rdWord_q <= regRdStb_q ? regRdData : 24'h000000;
        end
    end

    // Core facing outputs
    assign regRdStb  = regRdStb_q;
    assign regWrStb  = regWrStb_q;
    assign regIdx    = regIdx_q;
    assign regWrData = regWrData_q;
    assign opAbort   = opAbort_q;

endmodule : srap_port

// *** bench/srap_port_props.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module srap_port_props
    import srap_pkg::*;
#(
    parameter logic [6:0] FirstWordIdx = SRAP_FIRST_WORD_IDX,  // First 24-bit index
    parameter logic [6:0] FirstSeqIdx  = SRAP_FIRST_SEQ_IDX    // First 16-bit index
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Link
    input wire logic        sclk,
    input wire logic        chipSelectN,
    input wire logic        serialIn,
    input wire logic        sharedOutIrqPin,
    input wire logic        sharedOutIrqPinOe,
    // Core side
    input wire logic        wakeDone,
    input wire logic        opBusy,
    input wire logic        interruptN,
    input wire logic [23:0] regRdData,
    input wire logic        regRdStb,
    input wire logic        regWrStb,
    input wire logic [6:0]  regIdx,
    input wire logic [23:0] regWrData,
    input wire logic        opAbort
);
    logic       sclk_q;     // Link clock one cycle back
    logic [5:0] riseCnt_q;  // Link rises in this frame
    logic [5:0] wrEdge;     // Commit rise for regIdx
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    // Count link rises, cleared while deselected
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q    <= 1'b0;
            riseCnt_q <= 6'h00;
        end else begin
            sclk_q <= sclk;
            if (chipSelectN) begin
                riseCnt_q <= 6'h00;
            end else if (sclk && !sclk_q && riseCnt_q != 6'h3F) begin
                riseCnt_q <= riseCnt_q + 6'h01;
            end
        end
    end
    // Commit rise from map of index
    always_comb begin
        wrEdge = (regIdx < FirstWordIdx) ? 6'h10 : (regIdx < FirstSeqIdx) ? 6'h20 : 6'h18;
    end
    sequence csLowSeq;
        $fell(chipSelectN) ##1 (!chipSelectN) [*3];
    endsequence
    sequence csHighSeq;
        $rose(chipSelectN) ##1 chipSelectN [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    AST_WR_EDGE: assert property (regWrStb |-> riseCnt_q == wrEdge)
        else $error("write strobe not at commit rise");
    AST_RD_EDGE: assert property (regRdStb |-> riseCnt_q == 6'h08)
        else $error("read strobe not after address byte");
    AST_WAKE: assert property ((!wakeDone) [*5] |-> !regWrStb && !regRdStb)
        else $error("access taken before wakeup");
    AST_ABORT_BUSY: assert property (regWrStb && $past(opBusy) |-> opAbort)
        else $error("write did not abort busy operation");
    AST_ABORT_WR: assert property (opAbort |-> regWrStb)
        else $error("abort without write");
    AST_RD_QUIET: assert property (regRdStb |-> !opAbort && !regWrStb)
        else $error("read disturbed operation");
    AST_WR_PULSE: assert property (regWrStb |=> !regWrStb && !regRdStb)
        else $error("second access in frame");
    AST_OE_ON: assert property (csLowSeq |=> sharedOutIrqPinOe)
        else $error("pin not driven in frame");
    AST_OE_OFF: assert property (csHighSeq |=> !sharedOutIrqPinOe)
        else $error("pin driven outside frame");
    AST_IRQ_PIN: assert property (sharedOutIrqPinOe && $past(sharedOutIrqPinOe)
        && riseCnt_q < 6'h08 && interruptN == $past(interruptN)
        && interruptN == $past(interruptN, 2) && interruptN == $past(interruptN, 3)
        |-> sharedOutIrqPin == interruptN)
        else $error("pin not showing interrupt");
endmodule : srap_port_props

bind srap_port srap_port_props #(
    .FirstWordIdx(FirstWordIdx),
    .FirstSeqIdx (FirstSeqIdx)
) srap_port_props_i (
    .clk(clk), .rstn(rstn), .sclk(sclk), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .sharedOutIrqPin(sharedOutIrqPin),
    .sharedOutIrqPinOe(sharedOutIrqPinOe), .wakeDone(wakeDone), .opBusy(opBusy),
    .interruptN(interruptN), .regRdData(regRdData), .regRdStb(regRdStb),
    .regWrStb(regWrStb), .regIdx(regIdx), .regWrData(regWrData), .opAbort(opAbort)
);

// *** bench/srap_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module srap_host_model (
    // Link driven by the host
    output logic sclk,
    output logic chipSelectN,
    output logic serialIn,
    // Shared pin from the device
    input  wire logic sharedOutIrqPin,
    input  wire logic sharedOutIrqPinOe
);
    logic irqSeen;  // Pin level before the first rise
    wire  pinLevel = sharedOutIrqPinOe ? sharedOutIrqPin : 1'bz;  // Undriven floats
    initial begin
        sclk        = 1'b0;
        chipSelectN = 1'b1;
        serialIn    = 1'b0;
    end
    // one access per frame, 48 ns link period
    task automatic xfer(input logic [7:0] addr, input logic [23:0] wd,
                        input int nb, input int stopAt, output logic [23:0] rd);
        logic [32:0] sh;
        int          n;
        sh = {addr, 24'(wd << (8 * (3 - nb))), 1'b0};
        n  = (addr[7] ? 9 : 8) + 8 * nb;
        rd = 24'h000000;
        #7 chipSelectN = 1'b0;
        #200;
        irqSeen = pinLevel;
        for (int i = 0; i < n; i++) begin
            if (i == stopAt) break;
            // data set while low, MSB first
            serialIn = sh[32-i];
            #24 sclk = 1'b1;
            if (i >= 9) rd = {rd[22:0], pinLevel};
            #24 sclk = 1'b0;
            if (i == 7 && addr[7]) #200;
        end
        #124 chipSelectN = 1'b1;
        serialIn = ~serialIn;
        #100;
    endtask : xfer
endmodule : srap_host_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic        clk = 1'b0, rstn = 1'b0;       // System clock and reset
    logic        wakeDone = 1'b0, opBusy = 1'b0; // Core status
    logic        interruptN = 1'b1;              // Core interrupt level
    logic [23:0] regRdData = 24'h000000;         // Core read word
    wire         sclk, chipSelectN, serialIn, sharedOutIrqPin, sharedOutIrqPinOe;
    wire         regRdStb, regWrStb, opAbort;
    wire  [6:0]  regIdx;
    wire  [23:0] regWrData;
    int          fails = 0, checksDone = 0;       // Verdict counters
    int          wrCnt = 0, rdCnt = 0, abCnt = 0; // Strobe counts
    logic [6:0]  wrIdx, rdIdx;                    // Last written and read index
    logic [23:0] wrWord, rd;                      // Last write, last read
    always #10 clk = ~clk;
    srap_port srap_port_i (.clk(clk), .rstn(rstn), .sclk(sclk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .sharedOutIrqPin(sharedOutIrqPin),
        .sharedOutIrqPinOe(sharedOutIrqPinOe), .wakeDone(wakeDone), .opBusy(opBusy),
        .interruptN(interruptN), .regRdData(regRdData), .regRdStb(regRdStb),
        .regWrStb(regWrStb), .regIdx(regIdx), .regWrData(regWrData), .opAbort(opAbort));
    srap_host_model srap_host_model_i (.sclk(sclk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .sharedOutIrqPin(sharedOutIrqPin),
        .sharedOutIrqPinOe(sharedOutIrqPinOe));
    // Collect strobes where settled
    always @(negedge clk) begin
        if (regWrStb === 1'b1) begin
            wrCnt++;
            wrIdx  = regIdx;
            wrWord = regWrData;
        end
        if (regRdStb === 1'b1) begin
            rdCnt++;
            rdIdx = regIdx;
        end
        if (opAbort === 1'b1) abCnt++;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic core(input logic wk, input logic busy, input logic irqN,
                        input logic [23:0] word);
        @(negedge clk);
        wakeDone   = wk;
        opBusy     = busy;
        interruptN = irqN;
        regRdData  = word;
    endtask : core
    // Accesses before wakeup are dropped
    task automatic t_wake();
        core(1'b0, 1'b1, 1'b1, 24'hFFFFFF);
        srap_host_model_i.xfer(8'h05, 24'h0000A5, 1, 99, rd);
        srap_host_model_i.xfer(8'hA0, 24'h000000, 3, 99, rd);
        check(24'(wrCnt + rdCnt + abCnt), 24'h000000);
        check(rd, 24'h000000);
    endtask : t_wake
    // Writes of every width, first one while busy
    task automatic t_write();
        logic [6:0]  ix[3] = '{7'h05, 7'h25, 7'h3A};
        logic [23:0] wd[3] = '{24'h0000A5, 24'hC3A55A, 24'h0081F0};
        int          nb[3] = '{1, 3, 2};
        int          w0, a0;
        for (int k = 0; k < 3; k++) begin
            core(1'b1, k == 0, 1'b1, 24'h000000);
            w0 = wrCnt;
            a0 = abCnt;
            srap_host_model_i.xfer({1'b0, ix[k]}, wd[k], nb[k], 99, rd);
            check(24'(wrCnt - w0), 24'h000001);
            check({17'h00000, wrIdx}, {17'h00000, ix[k]});
            check(wrWord, wd[k]);
            check(24'(abCnt - a0), (k == 0) ? 24'h000001 : 24'h000000);
        end
    endtask : t_write
    // Reads of every width while busy, interrupt shown first
    task automatic t_read();
        logic [6:0]  ix[3] = '{7'h20, 7'h3B, 7'h07};
        logic [23:0] wd[3] = '{24'hA1B2C3, 24'h005A3C, 24'h000096};
        int          nb[3] = '{3, 2, 1};
        int          r0, a0;
        for (int k = 0; k < 3; k++) begin
            core(1'b1, 1'b1, k[0], wd[k]);
            r0 = rdCnt;
            a0 = abCnt;
            srap_host_model_i.xfer({1'b1, ix[k]}, 24'h000000, nb[k], 99, rd);
            check(rd, wd[k]);
            check(24'(rdCnt - r0), 24'h000001);
            check({17'h00000, rdIdx}, {17'h00000, ix[k]});
            check(24'(abCnt - a0), 24'h000000);
            check({23'h000000, srap_host_model_i.irqSeen}, {23'h000000, k[0]});
        end
    endtask : t_read
    // Deselect before commit, then a clean frame
    task automatic t_abort();
        int w0;
        core(1'b1, 1'b0, 1'b1, 24'h000000);
        w0 = wrCnt;
        srap_host_model_i.xfer(8'h05, 24'h00005A, 1, 15, rd);
        check(24'(wrCnt - w0), 24'h000000);
        srap_host_model_i.xfer(8'h06, 24'h00003C, 1, 99, rd);
        check({17'h00000, wrIdx}, 24'h000006);
        check(wrWord, 24'h00003C);
    endtask : t_abort
    task automatic complete_run();
        $display("checks %0d fails %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // Watchdog over the whole sequence
    initial begin
        #300us;
        fails++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_wake();
        t_write();
        t_read();
        t_abort();
        complete_run();
    end
endmodule : tb_top
